// ---- hdl/edc_regs.vh ----
/*
 * Constants for the page-mode DRAM controller: timing counts at 125 MHz
 * and address layout. Included by edc_ctrl; the synchroniser does not include it.
 */
`ifndef EDC_REGS_VH
`define EDC_REGS_VH

// ****************************************************************
// Timing
// ****************************************************************
`define EDC_CLK_PERIOD_NS 8
`define EDC_PWRUP_US 200
`define EDC_PWRUP_CYC \
	((`EDC_PWRUP_US * 1000 + `EDC_CLK_PERIOD_NS - 1) / `EDC_CLK_PERIOD_NS)
`define EDC_REFRESH_MS 8
`define EDC_REFRESH_ROWS 512
`define EDC_REFRESH_WINDOW_CYC (`EDC_REFRESH_MS * 1000000 / `EDC_CLK_PERIOD_NS)
// Room for an access and precharge to finish before a refresh starts
`define EDC_REFRESH_SLACK_CYC 64
`define EDC_STALE_CYC (2 * `EDC_REFRESH_WINDOW_CYC / `EDC_REFRESH_ROWS)
`define EDC_WAKE_CYCLES 8
`define EDC_RAS_LOW_NS 60
`define EDC_RAS_LOW_CYC \
	((`EDC_RAS_LOW_NS + `EDC_CLK_PERIOD_NS - 1) / `EDC_CLK_PERIOD_NS)
`define EDC_RAS_PRE_NS 40
`define EDC_RAS_PRE_CYC \
	((`EDC_RAS_PRE_NS + `EDC_CLK_PERIOD_NS - 1) / `EDC_CLK_PERIOD_NS)
`define EDC_CAS_PULSE_NS 15
`define EDC_CAS_PULSE_CYC \
	((`EDC_CAS_PULSE_NS + `EDC_CLK_PERIOD_NS - 1) / `EDC_CLK_PERIOD_NS)
`define EDC_RCD_NS 20
`define EDC_RCD_CYC \
	((`EDC_RCD_NS + `EDC_CLK_PERIOD_NS - 1) / `EDC_CLK_PERIOD_NS)

// ****************************************************************
// Widths and reset values
// ****************************************************************
`define EDC_ADDR_W 9
`define EDC_DATA_W 16
`define EDC_TIMER_W 20
`define EDC_ROW_LSB 9
`define EDC_STROBE_IDLE 1'b1

`endif

// ---- hdl/edc_sync.v ----
/*
 * Two-flop synchroniser for an input bus from outside the clock domain.
 * Assumes the bus is sampled only for values stable across a strobe edge.
 */
`timescale 1ns/1ps
module edc_sync #(parameter W = 16)
(
	input wire mclk,
	input wire rst,
	input wire [W-1:0] d,
	output reg [W-1:0] q
);
reg [W-1:0] meta_ff;

always @(posedge mclk or posedge rst)
begin
	if (rst)
	begin
		meta_ff <= {W{1'b0}};
		q <= {W{1'b0}};
	end
	else
	begin
		meta_ff <= d;
		q <= meta_ff;
	end
end
endmodule

// ---- hdl/edc_ctrl.v ----
/*
 * Page-mode DRAM controller: power-up wait, wake-up strobes, periodic
 * column-first refresh, and page accesses within one open row.
 * Assumes a 256K x 16 asynchronous DRAM on the pins and a user
 * that holds req until ack.
 */
//
// Contract
// RULE_01: 512 row refreshes must reach the memory in every 8 ms.
// RULE_02: With explicit row refresh, all 512 rows get a row strobe per 8 ms.
// RULE_03: Any access or row-only cycle refreshes the addressed row.
// RULE_04: Row strobe falling while a column strobe is low means refresh.
// RULE_05: Column-first refresh uses the internal row counter, not the pins.
// RULE_06: Column-first refresh moves no data; data pins stay undriven.
// RULE_07: Columns of an open row may be accessed in any order.
// RULE_08: Page read data holds until the next column strobe falls.
// RULE_09: Reads and writes may be mixed inside one open row.
// RULE_10: After power-up wait 200 us, then give eight row strobe cycles.
// RULE_11: After a missed refresh window, repeat the eight wake-up cycles.
// RULE_12: Keep the row strobe high while powering up.
// RULE_13: A cycle starts at row strobe low, ends with all strobes high.
// RULE_14: Lower strobe gates bits 0-7, upper gates bits 8-15.
// RULE_15: The device row counter advances after each column-first refresh.
`timescale 1ns/1ps
`include "edc_regs.vh"
module edc_ctrl
(
	input wire mclk,
	input wire rst,
	input wire req,
	input wire req_write,
	input wire [17:0] req_addr,
	input wire [1:0] req_byte_en,
	input wire [15:0] req_wdata,
	input wire req_last,
	output reg ack_ff,
	output reg [15:0] rdata_ff,
	output reg ready_ff,
	output reg row_strobe_n_ff,
	output reg lower_byte_column_strobe_n_ff,
	output reg upper_byte_column_strobe_n_ff,
	output reg write_enable_n_ff,
	output reg output_enable_n_ff,
	output reg [8:0] muxed_address_bus_ff,
	output reg [15:0] data_bus_out_ff,
	output reg data_bus_oe_ff,
	input wire [15:0] data_bus_in
);

// ****************************************************************
// States
// ****************************************************************
localparam ST_PWRUP = 9'h001;
localparam ST_IDLE = 9'h002;
localparam ST_RF_CAS = 9'h004;
localparam ST_RF_RAS = 9'h008;
localparam ST_PRE = 9'h010;
localparam ST_ROW = 9'h020;
localparam ST_COL = 9'h040;
localparam ST_CAS_HI = 9'h080;
localparam ST_PAGE = 9'h100;

reg [8:0] state_ff;
reg [`EDC_TIMER_W-1:0] tmr_ff;
reg [`EDC_TIMER_W-1:0] rf_tmr_ff;
reg [3:0] wake_ff;
reg [8:0] open_row_ff;
reg wr_ff;
wire [15:0] din_sync;

edc_sync #(.W(`EDC_DATA_W)) u_din_sync
(
	.mclk(mclk),
	.rst(rst),
	.d(data_bus_in),
	.q(din_sync)
);

function [`EDC_TIMER_W-1:0] cyc;
	input integer n;
	begin
		cyc = n[`EDC_TIMER_W-1:0];
	end
endfunction

// Refresh falls due slack cycles short of window / rows, so 512 fit each 8 ms
wire refresh_due = rf_tmr_ff >=
	cyc(`EDC_REFRESH_WINDOW_CYC / `EDC_REFRESH_ROWS
	- `EDC_REFRESH_SLACK_CYC); // RULE_01
wire tmr_done = tmr_ff == {`EDC_TIMER_W{1'b0}};

// ****************************************************************
// Sequencer
// ****************************************************************
always @(posedge mclk or posedge rst)
begin
	if (rst)
	begin
		state_ff <= ST_PWRUP;
		tmr_ff <= cyc(`EDC_PWRUP_CYC);
		rf_tmr_ff <= {`EDC_TIMER_W{1'b0}};
		wake_ff <= 4'h0;
		open_row_ff <= 9'h000;
		wr_ff <= 1'b0;
		ack_ff <= 1'b0;
		rdata_ff <= 16'h0000;
		ready_ff <= 1'b0;
		row_strobe_n_ff <= `EDC_STROBE_IDLE; // RULE_12
		lower_byte_column_strobe_n_ff <= `EDC_STROBE_IDLE;
		upper_byte_column_strobe_n_ff <= `EDC_STROBE_IDLE;
		write_enable_n_ff <= 1'b1;
		output_enable_n_ff <= 1'b1;
		muxed_address_bus_ff <= 9'h000;
		data_bus_out_ff <= 16'h0000;
		data_bus_oe_ff <= 1'b0;
	end
	else
	begin
		ack_ff <= 1'b0;
		if (!tmr_done)
			tmr_ff <= tmr_ff - cyc(1);
		if (state_ff == ST_RF_RAS && tmr_done)
			rf_tmr_ff <= {`EDC_TIMER_W{1'b0}};
		else if (rf_tmr_ff != {`EDC_TIMER_W{1'b1}})
			rf_tmr_ff <= rf_tmr_ff + cyc(1);
		// Counter passing its period twice means rows went stale
		if (rf_tmr_ff >= cyc(`EDC_STALE_CYC) && ready_ff)
		begin
			ready_ff <= 1'b0; // RULE_11
			wake_ff <= 4'h0;
		end
		case (state_ff)
		ST_PWRUP:
			if (tmr_done)
				state_ff <= ST_IDLE; // RULE_10
		ST_IDLE:
		begin
			data_bus_oe_ff <= 1'b0;
			output_enable_n_ff <= 1'b1;
			write_enable_n_ff <= 1'b1;
			if (refresh_due || !ready_ff)
			begin
				// Column strobes first, row strobe later
				lower_byte_column_strobe_n_ff <= 1'b0; // RULE_04
				upper_byte_column_strobe_n_ff <= 1'b0;
				data_bus_oe_ff <= 1'b0; // RULE_06
				tmr_ff <= cyc(`EDC_CAS_PULSE_CYC);
				// Device counter walks all rows; no explicit row walk
				state_ff <= ST_RF_CAS; // RULE_02
			end
			else if (req)
			begin
				open_row_ff <= req_addr[17:`EDC_ROW_LSB];
				muxed_address_bus_ff <= req_addr[17:`EDC_ROW_LSB];
				row_strobe_n_ff <= 1'b0; // RULE_13
				tmr_ff <= cyc(`EDC_RCD_CYC);
				state_ff <= ST_ROW; // RULE_03
			end
		end
		ST_RF_CAS:
			if (tmr_done)
			begin
				// Address pins ignored; device counter picks the row
				row_strobe_n_ff <= 1'b0; // RULE_05
				tmr_ff <= cyc(`EDC_RAS_LOW_CYC);
				state_ff <= ST_RF_RAS;
			end
		ST_RF_RAS:
			if (tmr_done)
			begin
				row_strobe_n_ff <= 1'b1;
				lower_byte_column_strobe_n_ff <= 1'b1;
				upper_byte_column_strobe_n_ff <= 1'b1;
				if (!ready_ff)
				begin
					wake_ff <= wake_ff + 4'h1;
					if ({{(`EDC_TIMER_W-4){1'b0}}, wake_ff}
						== cyc(`EDC_WAKE_CYCLES - 1))
						ready_ff <= 1'b1; // RULE_10
				end
				tmr_ff <= cyc(`EDC_RAS_PRE_CYC);
				state_ff <= ST_PRE;
			end
		ST_PRE:
			if (tmr_done)
				state_ff <= ST_IDLE; // RULE_13
		ST_ROW:
			if (tmr_done)
			begin
				muxed_address_bus_ff <= req_addr[8:0]; // RULE_07
				wr_ff <= req_write;
				write_enable_n_ff <= !req_write; // RULE_09
				output_enable_n_ff <= req_write;
				data_bus_out_ff <= req_wdata;
				data_bus_oe_ff <= req_write;
				lower_byte_column_strobe_n_ff <= !req_byte_en[0]; // RULE_14
				upper_byte_column_strobe_n_ff <= !req_byte_en[1];
				tmr_ff <= cyc(`EDC_CAS_PULSE_CYC + 2);
				state_ff <= ST_COL;
			end
		ST_COL:
			if (tmr_done)
			begin
				// Extra cycles cover the input synchroniser delay
				if (!wr_ff)
				begin
					rdata_ff <= din_sync; // RULE_08
				end
				ack_ff <= 1'b1;
				lower_byte_column_strobe_n_ff <= 1'b1;
				upper_byte_column_strobe_n_ff <= 1'b1;
				tmr_ff <= cyc(`EDC_CAS_PULSE_CYC);
				state_ff <= ST_CAS_HI;
			end
		ST_CAS_HI:
			if (tmr_done)
				state_ff <= ST_PAGE;
		ST_PAGE:
		begin
			data_bus_oe_ff <= 1'b0;
			write_enable_n_ff <= 1'b1;
			if (req && !req_last && !refresh_due
				&& req_addr[17:`EDC_ROW_LSB] == open_row_ff)
			begin
				tmr_ff <= {`EDC_TIMER_W{1'b0}};
				state_ff <= ST_ROW; // RULE_07
			end
			else if (!req || req_last || refresh_due
				|| req_addr[17:`EDC_ROW_LSB] != open_row_ff)
			begin
				row_strobe_n_ff <= 1'b1; // RULE_13
				output_enable_n_ff <= 1'b1;
				tmr_ff <= cyc(`EDC_RAS_PRE_CYC);
				state_ff <= ST_PRE;
			end
		end
		default:
			state_ff <= ST_IDLE;
		endcase
	end
end

endmodule

// ---- test/edc_chk_checker.sv ----
/* Pin checks for edc_ctrl.
   Bound to edc_ctrl; one clock, reset rst. */
`timescale 1ns/1ps
module edc_chk
(
	input wire mclk,
	input wire rst,
	input wire ack_ff,
	input wire ready_ff,
	input wire row_strobe_n_ff,
	input wire lower_byte_column_strobe_n_ff,
	input wire upper_byte_column_strobe_n_ff,
	input wire output_enable_n_ff,
	input wire data_bus_oe_ff
);
	wire ras = row_strobe_n_ff;
	wire cas = lower_byte_column_strobe_n_ff & upper_byte_column_strobe_n_ff;
	reg [14:0] up_ff;
	reg [3:0] fall_ff;
	reg [13:0] gap_ff;
	reg ras_d_ff;
	reg rdy_d_ff;
	always @(posedge mclk or posedge rst)
	begin
		if (rst)
		begin
			up_ff <= 15'h0000;
			fall_ff <= 4'h0;
			gap_ff <= 14'h0000;
			ras_d_ff <= 1'h1;
			rdy_d_ff <= 1'h0;
		end
		else
		begin
			ras_d_ff <= ras;
			rdy_d_ff <= ready_ff;
			if (up_ff != 15'h7FFF) up_ff <= up_ff + 15'h0001;
			if (rdy_d_ff & !ready_ff) fall_ff <= 4'h0;
			else if (ras_d_ff & !ras & fall_ff != 4'hF) fall_ff <= fall_ff + 4'h1;
			// Only column-first falls count as refresh
			if (ras_d_ff & !ras & !cas) gap_ff <= 14'h0000;
			else if (gap_ff != 14'h3FFF) gap_ff <= gap_ff + 14'h0001;
		end
	end
	default clocking @(posedge mclk); endclocking
	default disable iff (rst);
	pwrup_quiet_a: assert property (up_ff < 15'h6190 |-> ras && cas)
		else $error("strobe moved in power-up wait");
	wake_count_a: assert property ($rose(ready_ff) |-> fall_ff >= 4'h8)
		else $error("ready before eight row cycles");
	refresh_gap_a: assert property (ready_ff |-> gap_ff < 14'h07A1)
		else $error("refresh interval exceeded");
	refresh_quiet_a: assert property ($fell(ras) && !cas |-> !data_bus_oe_ff)
		else $error("data driven in refresh");
	ras_width_a: assert property ($fell(ras) |=> !ras [*7])
		else $error("row strobe low too short");
	precharge_a: assert property ($rose(ras) |=> ras [*4])
		else $error("row precharge too short");
	no_fight_a: assert property (!(data_bus_oe_ff && !output_enable_n_ff))
		else $error("data bus contention");
	ack_in_row_a: assert property (ack_ff |-> !ras && ready_ff)
		else $error("access outside open row");
endmodule
bind edc_ctrl edc_chk chk (.*);

// ---- test/edc_dram_model.sv ----
/* Behavioural memory on the far side of edc_ctrl.
   Acts on strobe edges only; no timing checks. */
`timescale 1ns/1ps
module edc_dram_model
(
	input wire ras_n,
	input wire lo_strobe_n,
	input wire hi_strobe_n,
	input wire we_n,
	input wire oe_n,
	input wire [8:0] a,
	input wire [15:0] d_in,
	output logic [15:0] d_out,
	output logic [8:0] rc
);
	logic [15:0] mem [0:262143];
	logic [8:0] row;
	logic [15:0] rd = 16'h0000;
	logic [15:0] lane = 16'h0000;
	logic col_first = 1'h0;
	wire cas_n = lo_strobe_n & hi_strobe_n;
	wire [15:0] on = lane & {16{!oe_n}};
	// Released lanes show the inverse, never a stale value
	assign d_out = (rd & on) | (~rd & ~on);
	initial rc = 9'h000;
	always @(negedge ras_n)
	begin
		// Address changes in the same step as the strobe
		#1;
		col_first = !cas_n;
		if (col_first) rc = rc + 9'h001;
		else row = a;
	end
	always @(posedge ras_n) lane = 16'h0000;
	always @(negedge cas_n)
	begin
		#1;
		if (!ras_n && !col_first)
		begin
			if (!we_n && !lo_strobe_n)
				mem[{row, a}][7:0] = d_in[7:0];
			if (!we_n && !hi_strobe_n)
				mem[{row, a}][15:8] = d_in[15:8];
			rd = mem[{row, a}];
			lane = we_n ? {{8{!hi_strobe_n}}, {8{!lo_strobe_n}}} : 16'h0000;
		end
	end
endmodule

// ---- test/tb_top.sv ----
/* Bench for edc_ctrl with the memory model.
   The model answers on strobe edges. */
`timescale 1ns/1ps
module tb_top;
	logic mclk, rst, req, rw, last;
	logic [17:0] ra;
	logic [1:0] be;
	logic [15:0] wd, got;
	logic [8:0] k;
	wire ack, rdy, ras, lc, uc, we, oe, doe;
	wire [8:0] ma, rc;
	wire [15:0] rdat, dout, md, din;
	int n_mismatch, checked;
	assign din = doe ? dout : md;
	edc_ctrl dut (.mclk(mclk), .rst(rst), .req(req), .req_write(rw),
		.req_addr(ra), .req_byte_en(be), .req_wdata(wd), .req_last(last),
		.ack_ff(ack), .rdata_ff(rdat), .ready_ff(rdy), .row_strobe_n_ff(ras),
		.lower_byte_column_strobe_n_ff(lc),
		.upper_byte_column_strobe_n_ff(uc), .write_enable_n_ff(we),
		.output_enable_n_ff(oe), .muxed_address_bus_ff(ma),
		.data_bus_out_ff(dout), .data_bus_oe_ff(doe), .data_bus_in(din));
	edc_dram_model mem (.ras_n(ras), .lo_strobe_n(lc), .hi_strobe_n(uc),
		.we_n(we),
		.oe_n(oe), .a(ma), .d_in(dout), .d_out(md), .rc(rc));
	initial
	begin
		mclk = 1'h0;
		forever #4 mclk = ~mclk;
	end
	task chk(input logic [15:0] s, input logic [15:0] e, input string w);
	begin
		checked++;
		if (s !== e)
		begin
			n_mismatch++;
			$display("ERROR %s expected %h seen %h", w, e, s);
		end
	end
	endtask
	task complete_run;
	begin
		$display("checks %0d mismatches %0d", checked, n_mismatch);
		if (n_mismatch == 0 && checked > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	end
	endtask
	task acc(input logic w, input logic [17:0] a, input logic [1:0] b,
		input logic [15:0] d, input logic l);
		int i;
	begin
		@(posedge mclk);
		req <= 1'h1;
		rw <= w;
		ra <= a;
		be <= b;
		wd <= d;
		last <= l;
		i = 0;
		do
		begin
			@(posedge mclk);
			i++;
		end
		while (ack !== 1'h1 && i < 400);
		got = rdat;
		chk({15'h0000, ack}, 16'h0001, "ack");
		req <= 1'h0;
	end
	endtask
	task t_wake;
		int i;
	begin
		rst <= 1'h1;
		repeat (8) @(posedge mclk);
		rst <= 1'h0;
		repeat (100) @(posedge mclk);
		chk({12'h000, ras, lc, uc, rdy}, 16'h000E, "quiet");
		k = rc;
		for (i = 0; i < 26000 && rdy !== 1'h1; i++) @(posedge mclk);
		chk({15'h0000, rdy}, 16'h0001, "ready");
		chk({15'h0000, 9'(rc - k) >= 9'h008}, 16'h0001, "wake");
		$display("wake test done");
	end
	endtask
	task t_page;
	begin
		acc(1'h1, 18'h0A405, 2'h3, 16'hA5A5, 1'h0);
		acc(1'h1, 18'h0A401, 2'h3, 16'h1234, 1'h0);
		acc(1'h1, 18'h0A405, 2'h2, 16'h3C00, 1'h0);
		acc(0, 18'h0A405, 2'h3, 16'h0000, 1'h0);
		chk(got, 16'h3CA5, "upper lane");
		acc(1'h1, 18'h0A405, 2'h1, 16'h00FF, 1'h0);
		acc(0, 18'h0A401, 2'h3, 16'h0000, 1'h0);
		chk(got, 16'h1234, "any order");
		acc(0, 18'h0A405, 2'h3, 16'h0000, 1'h1);
		chk(got, 16'h3CFF, "mixed page");
		acc(1'h1, 18'h3FFFF, 2'h3, 16'hBEEF, 1'h1);
		acc(0, 18'h3FFFF, 2'h3, 16'h0000, 1'h1);
		chk(got, 16'hBEEF, "last cell");
		$display("page test done");
	end
	endtask
	task t_refresh;
	begin
		k = rc;
		repeat (16000) @(posedge mclk);
		// 16000 cycles hold at least eight refresh periods
		chk({15'h0000, 9'(rc - k) >= 9'h008}, 16'h0001, "refresh");
		acc(0, 18'h0A401, 2'h3, 16'h0000, 1'h1);
		chk(got, 16'h1234, "kept");
		$display("refresh test done");
	end
	endtask
	initial
	begin
		rst = 1'h1;
		req = 1'h0;
		rw = 1'h0;
		last = 1'h0;
		ra = 18'h00000;
		be = 2'h0;
		wd = 16'h0000;
		t_wake;
		t_page;
		t_refresh;
		// Second reset in mid-run
		t_wake;
		t_page;
		complete_run;
	end
	initial
	begin
		repeat (90000) @(posedge mclk);
		n_mismatch++;
		complete_run;
	end
endmodule
